/* File: rtl/wakeup_event_router.sv */
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "wakeup_event_router_defs.svh"
// Overview of operation
// - Leading edge of enabled module interrupt OR raises event
// - Module event sets bit 7, drives power-up
// - Falling modem ring input is a wake event
// - Record falling edges per 62.5 ms slot
// - Quiet slot then three busy slots detects
// - Button mode change interrupts; mode mirrored
// - Power-off write sets flag, may interrupt
// - S1-S5 writes set core request flags
// - All-zero state write sets working state flag
// - Enabled state request flags raise core interrupt
// - Clear by writing one or masking enable
// - Alarm status sets core alarm request flag
// - Four outputs: irq, power-up, sysmgmt, core wake
// - Host outputs from host bits, core separate
// - Three host routing enables, one bit per event
// - Outputs hold until set bits cleared or masked, save channel 1, 2 sysmgmt requests
// - Sysmgmt ORs internal and channel 1, 2 requests
// - Level-high core wake gathers enabled core requests
// - Valid flag held; no valid, config ignored
// - Status clears only on written one
module wakeup_event_router #(
  parameter int NUM_DEV     = 4,                  // Logical devices
  parameter int SLOT_CYCLES = `WER_RING_SLOT_CYC  // Ring slot length
) (
  input  wire logic                              core_clk,
  input  wire logic                              srst,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Wake sources
  input  wire logic [NUM_DEV-1:0]                modIrq,
  input  wire logic [NUM_DEV-1:0]                modIrqWakeEn,
  input  wire logic                              modemRingInAN,
  input  wire logic                              modemRingInBN,
  input  wire logic                              teleRingN,
  input  wire logic                              rtcAlarmStatus,
  input  wire logic                              pmChanOneSmi,
  input  wire logic                              pmChanTwoSmi,
  // Output events
  output wakeup_event_router_pkg::host_out_t     hostOut,
  output logic                                   coreWakeupInterrupt,
  // Host configuration address
  output logic      [15:0]                       configBaseAddr,
  output logic                                   configAddrValid
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  initial begin
    if (NUM_DEV < 1 || SLOT_CYCLES < 2) begin
      $error("wakeup_event_router: unsupported parameter values");
    end
  end

  localparam int CW = $clog2(SLOT_CYCLES);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [NUM_DEV+3:0] syncA_q;        // First stage, read by stage two
  logic [NUM_DEV+3:0] syncB_q;        // Second stage, safe to use
  logic [NUM_DEV+3:0] syncC_q;        // Delayed copy for edges
  logic [NUM_DEV+3:0] rawIn;          // Pin bundle

  assign rawIn = {modIrq, rtcAlarmStatus, teleRingN,
                  modemRingInBN, modemRingInAN};

  // Two flops for pins, a third for edge detection
  // Reset to each pin's idle level so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      syncA_q <= {{NUM_DEV{1'b0}}, 4'h7};
      syncB_q <= {{NUM_DEV{1'b0}}, 4'h7};
      syncC_q <= {{NUM_DEV{1'b0}}, 4'h7};
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  // ****************************************************************
  // Event detection
  // ****************************************************************
  logic ringAFall;                    // Modem ring A falling edge
  logic ringBFall;                    // Modem ring B falling edge
  logic teleFall;                     // Telephone ring falling edge
  logic alarmRise;                    // Alarm status set
  logic modNow;                       // OR of enabled device irqs
  logic modPrev_q;                    // Last value of that OR
  logic modRise;                      // Leading edge of module event

  assign ringAFall = syncC_q[0] & ~syncB_q[0];
  assign ringBFall = syncC_q[1] & ~syncB_q[1];
  assign teleFall  = syncC_q[2] & ~syncB_q[2];
  assign alarmRise = ~syncC_q[3] & syncB_q[3];
  assign modNow    = |(syncB_q[NUM_DEV+3:4] & modIrqWakeEn);
  assign modRise   = modNow & ~modPrev_q;

  // Edge memory for the combined module source
  always_ff @(posedge core_clk) begin
    if (srst) begin
      modPrev_q <= 1'b0;
    end else begin
      modPrev_q <= modNow;
    end
  end

  // ****************************************************************
  // Telephone ring slot detector
  // ****************************************************************
  logic [CW-1:0] slotCnt_q;           // Divider toward slot end
  logic          slotEnd;             // One-cycle slot enable
  logic          slotEdge_q;          // Edge seen in current slot
  logic [3:0]    slotHist_q;          // Newest slot in bit 0
  logic [3:0]    slotHistD;           // History after this slot
  logic          teleDetect;          // Pulse train recognised

  assign slotEnd   = (slotCnt_q == CW'(SLOT_CYCLES - 1));
  assign slotHistD = {slotHist_q[2:0], slotEdge_q | teleFall};
  assign teleDetect = slotEnd & (slotHistD == 4'h7);

  // Slot divider, a stand-in for the low-rate clock
  always_ff @(posedge core_clk) begin
    if (srst || slotEnd) begin
      slotCnt_q <= '0;
    end else begin
      slotCnt_q <= slotCnt_q + CW'(1);
    end
  end

  // Per-slot edge record and history
  always_ff @(posedge core_clk) begin
    if (srst) begin
      slotEdge_q <= 1'b0;
      slotHist_q <= 4'hF;             // Busy history forces quiet slot
    end else if (slotEnd) begin
      slotEdge_q <= 1'b0;
      slotHist_q <= slotHistD;
    end else if (teleFall) begin
      slotEdge_q <= 1'b1;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic wrEn;                         // Write takes effect
  logic rdSetup;                      // Setup phase of a read
  logic hit;                          // Address is mapped
  logic [31:0] rdMux;                 // Read data selection

  assign pready = 1'b1;               // Zero wait states
  assign wrEn   = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;

  // Write helper for one offset
  function automatic logic wrAt(input logic [11:0] off);
    wrAt = wrEn && (paddr == off);
  endfunction : wrAt

  // ****************************************************************
  // Host and core event status
  // ****************************************************************
  wakeup_event_router_pkg::event_vec_t newEv;
  wakeup_event_router_pkg::event_vec_t hostSts_q;
  wakeup_event_router_pkg::event_vec_t coreSts_q;
  wakeup_event_router_pkg::event_vec_t hostPwrEn_q;
  wakeup_event_router_pkg::event_vec_t hostSmiEn_q;
  wakeup_event_router_pkg::event_vec_t hostIrqEn_q;
  wakeup_event_router_pkg::event_vec_t coreEvEn_q;
  wakeup_event_router_pkg::event_vec_t hostClr;
  wakeup_event_router_pkg::event_vec_t coreClr;

  always_comb begin
    newEv = '0;
    newEv[`WER_EV_RING_A] = ringAFall;
    newEv[`WER_EV_RING_B] = ringBFall;
    newEv[`WER_EV_TELE]   = teleDetect;
    newEv[`WER_EV_MODIRQ] = modRise;
  end

  assign hostClr = wrAt(`WER_HOST_STATUS) ? pwdata[7:0] : '0;
  assign coreClr = wrAt(`WER_CORE_STATUS) ? pwdata[7:0] : '0;

  // Both copies set together; a set beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hostSts_q <= `WER_RST_BYTE;
      coreSts_q <= `WER_RST_BYTE;
    end else begin
      hostSts_q <= (hostSts_q & ~hostClr) | newEv;
      coreSts_q <= (coreSts_q & ~coreClr) | newEv;
    end
  end

  // Routing enables; clearing one never touches status
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hostPwrEn_q <= `WER_RST_BYTE;
      hostSmiEn_q <= `WER_RST_BYTE;
      hostIrqEn_q <= `WER_RST_BYTE;
      coreEvEn_q  <= `WER_RST_BYTE;
    end else begin
      if (wrAt(`WER_HOST_PWRUP_EN)) begin
        hostPwrEn_q <= pwdata[7:0] & `WER_EV_MASK;
      end
      if (wrAt(`WER_HOST_SMI_EN)) begin
        hostSmiEn_q <= pwdata[7:0] & `WER_EV_MASK;
      end
      if (wrAt(`WER_HOST_IRQ_EN)) begin
        hostIrqEn_q <= pwdata[7:0] & `WER_EV_MASK;
      end
      if (wrAt(`WER_CORE_EVENT_EN)) begin
        coreEvEn_q <= pwdata[7:0] & `WER_EV_MASK;
      end
    end
  end

  // ****************************************************************
  // Host power requests and core control registers
  // ****************************************************************
  logic       btnMode_q;              // Host power button mode
  logic [8:0] ctrlTwo_q;              // State, power-off, mode change
  logic       alarmFlag_q;            // Alarm request flag
  logic [8:0] coreIntEn_q;            // Core interrupt enables
  logic [8:0] ctrlTwoSet;             // Hardware sets this cycle
  logic [8:0] ctrlTwoClr;             // Firmware clears this cycle
  logic       acpiWr;                 // Host state register written

  assign acpiWr = wrAt(`WER_ACPI_STATE);

  always_comb begin
    ctrlTwoSet = '0;
    if (acpiWr && pwdata[7:0] == `WER_RST_BYTE) begin
      ctrlTwoSet[0] = 1'b1;
    end else if (acpiWr) begin
      ctrlTwoSet[5:1] = pwdata[4:0];
    end
    if (wrAt(`WER_HOST_PWR_CFG)) begin
      ctrlTwoSet[`WER_C2_PSO] = pwdata[`WER_PCFG_PSO];
      ctrlTwoSet[`WER_C2_BTNCHG] =
        pwdata[`WER_PCFG_BTN] ^ btnMode_q;
    end
  end

  // Mirror bit is not a flag and cannot be cleared
  assign ctrlTwoClr = wrAt(`WER_CORE_CTRL_TWO) ?
                      (pwdata[8:0] & 9'h17F) : '0;

  // Button mode, held for the mirror and change detection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      btnMode_q <= 1'b0;
    end else if (wrAt(`WER_HOST_PWR_CFG)) begin
      btnMode_q <= pwdata[`WER_PCFG_BTN];
    end
  end

  // Request flags in the second control register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrlTwo_q <= '0;
    end else begin
      ctrlTwo_q <= (ctrlTwo_q & ~ctrlTwoClr) | ctrlTwoSet;
    end
  end

  // Alarm flag; set beats clear so no alarm is lost
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alarmFlag_q <= 1'b0;
    end else if (alarmRise) begin
      alarmFlag_q <= 1'b1;
    end else if (wrAt(`WER_CORE_CTRL_THREE) &&
                 pwdata[`WER_C3_ALARM]) begin
      alarmFlag_q <= 1'b0;
    end
  end

  // Core interrupt enable register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      coreIntEn_q <= '0;
    end else if (wrAt(`WER_CORE_INT_EN)) begin
      coreIntEn_q <= pwdata[8:0];
    end
  end

  // ****************************************************************
  // Configuration base address
  // ****************************************************************
  logic cfgLock_q;                    // Blocks base address writes
  logic cfgValid_q;                   // Base address usable

  // Address bytes move only while unlocked
  always_ff @(posedge core_clk) begin
    if (srst) begin
      configBaseAddr <= 16'h0000;
    end else if (!cfgLock_q) begin
      if (wrAt(`WER_CFG_BASE_LOW)) begin
        configBaseAddr[7:0] <= pwdata[7:0];
      end
      if (wrAt(`WER_CFG_BASE_HIGH)) begin
        configBaseAddr[15:8] <= pwdata[7:0];
      end
    end
  end

  // Valid clears on written one; lock with address makes it valid
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfgLock_q  <= 1'b0;
      cfgValid_q <= 1'b0;
    end else if (wrAt(`WER_CORE_CTRL_ONE)) begin
      if (pwdata[`WER_C1_VALID]) begin
        cfgValid_q <= 1'b0;
        cfgLock_q  <= 1'b0;
      end else if (pwdata[`WER_C1_LOCK]) begin
        cfgLock_q  <= 1'b1;
        cfgValid_q <= 1'b1;
      end
    end
  end

  assign configAddrValid = cfgValid_q;   // Host decoder gate

  // ****************************************************************
  // Output events
  // ****************************************************************
  logic [8:0] stateMask;              // Core enables for ctrlTwo

  assign stateMask = {coreIntEn_q[`WER_IE_BTN], coreIntEn_q[`WER_IE_BTN],
                      coreIntEn_q[`WER_IE_PSO], coreIntEn_q[5:0]} &
                     9'h17F;

  // Levels re-evaluated each cycle, so they deassert once bits go
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hostOut <= '{powerUpRequestN: 1'b1, sysMgmtIntN: 1'b1,
                   hostIrqReq: 1'b0};
      coreWakeupInterrupt <= 1'b0;
    end else begin
      hostOut.powerUpRequestN <= ~|(hostSts_q & hostPwrEn_q);
      hostOut.sysMgmtIntN <= ~(|(hostSts_q & hostSmiEn_q) |
                               pmChanOneSmi | pmChanTwoSmi);
      hostOut.hostIrqReq <= |(hostSts_q & hostIrqEn_q);
      coreWakeupInterrupt <= |(coreSts_q & coreEvEn_q) |
                             |(ctrlTwo_q & stateMask) |
                             (alarmFlag_q &
                              coreIntEn_q[`WER_IE_ALARM]);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    hit   = 1'b1;
    rdMux = `WER_RST_WORD;
    case (paddr)
      `WER_HOST_STATUS:     rdMux[7:0] = hostSts_q;
      `WER_HOST_PWRUP_EN:   rdMux[7:0] = hostPwrEn_q;
      `WER_HOST_SMI_EN:     rdMux[7:0] = hostSmiEn_q;
      `WER_HOST_IRQ_EN:     rdMux[7:0] = hostIrqEn_q;
      `WER_ACPI_STATE:      rdMux = `WER_RST_WORD;   // Write only
      `WER_HOST_PWR_CFG:    rdMux[0] = btnMode_q;
      `WER_CORE_STATUS:     rdMux[7:0] = coreSts_q;
      `WER_CORE_EVENT_EN:   rdMux[7:0] = coreEvEn_q;
      `WER_CORE_CTRL_ONE:   rdMux[1:0] = {cfgLock_q, cfgValid_q};
      `WER_CORE_CTRL_TWO: begin
        rdMux[8:0] = ctrlTwo_q;
        rdMux[`WER_C2_BTN] = btnMode_q;
      end
      `WER_CORE_CTRL_THREE: rdMux[0] = alarmFlag_q;
      `WER_CORE_INT_EN:     rdMux[8:0] = coreIntEn_q;
      `WER_CFG_BASE_LOW:    rdMux[7:0] = configBaseAddr[7:0];
      `WER_CFG_BASE_HIGH:   rdMux[7:0] = configBaseAddr[15:8];
      default:              hit = 1'b0;              // Unmapped
    endcase
  end

  // Read data captured in setup, stable through access
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata <= `WER_RST_WORD;
    end else if (rdSetup) begin
      prdata <= rdMux;
    end
  end

  assign pslverr = psel & penable & ~hit;

endmodule : wakeup_event_router

/* File: rtl/wakeup_event_router_defs.svh */
`ifndef WAKEUP_EVENT_ROUTER_DEFS_SVH
`define WAKEUP_EVENT_ROUTER_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define WER_HOST_STATUS     12'h000
`define WER_HOST_PWRUP_EN   12'h004
`define WER_HOST_SMI_EN     12'h008
`define WER_HOST_IRQ_EN     12'h00C
`define WER_ACPI_STATE      12'h010
`define WER_HOST_PWR_CFG    12'h014
`define WER_CORE_STATUS     12'h020
`define WER_CORE_EVENT_EN   12'h024
`define WER_CORE_CTRL_ONE   12'h028
`define WER_CORE_CTRL_TWO   12'h02C
`define WER_CORE_CTRL_THREE 12'h030
`define WER_CORE_INT_EN     12'h034
`define WER_CFG_BASE_LOW    12'h038
`define WER_CFG_BASE_HIGH   12'h03C

// ****************************************************************
// Event status bit positions (host and core status alike)
// ****************************************************************
`define WER_EV_RING_A   0
`define WER_EV_RING_B   1
`define WER_EV_TELE     3
`define WER_EV_MODIRQ   7
`define WER_EV_MASK     8'h8B

// ****************************************************************
// Control field positions
// ****************************************************************
`define WER_PCFG_BTN    0
`define WER_PCFG_PSO    1
`define WER_C1_VALID    0
`define WER_C1_LOCK     1
`define WER_C2_PSO      6
`define WER_C2_BTN      7
`define WER_C2_BTNCHG   8
`define WER_C3_ALARM    0
`define WER_IE_PSO      6
`define WER_IE_BTN      7
`define WER_IE_ALARM    8

// ****************************************************************
// Reset values
// ****************************************************************
`define WER_RST_BYTE    8'h00
`define WER_RST_WORD    32'h0000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define WER_CLK_KHZ         200000
`define WER_RING_SLOT_US    62500
// Cycles per microsecond first: the full product would overflow a 32-bit int
`define WER_RING_SLOT_CYC   (`WER_RING_SLOT_US * (`WER_CLK_KHZ / 1000))

`endif

/* File: rtl/wakeup_event_router_pkg.sv */
package wakeup_event_router_pkg;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef logic [7:0] event_vec_t;   // One bit per wake event

  typedef struct packed {
    logic        sel;                // psel
    logic        enable;             // penable
    logic        write;              // pwrite
    logic [11:0] addr;               // paddr
    logic [31:0] wdata;              // pwdata
  } apb_req_t;

  typedef struct packed {
    logic powerUpRequestN;           // Power-up request, low active
    logic sysMgmtIntN;               // System management int, low
    logic hostIrqReq;                // Host interrupt channel request
  } host_out_t;

endpackage : wakeup_event_router_pkg

/* File: test/ring_source_model.sv */
`timescale 1ns/100ps
// ****
// Telephone line ring source
// ****
module ring_source_model #(
  parameter int GAP = 8           // Cycles between ring falls
) (
  input  wire logic core_clk,
  input  wire logic burst,        // Ring train wanted
  output logic      teleRingN     // Line, pulled high when idle
);
  int cnt = 0;                    // Phase within one ring cycle
  initial teleRingN = 1'b1;
  // Low half a cycle; rests high between trains like the pull-up
  always @(posedge core_clk) begin
    cnt <= burst ? (cnt + 1) % GAP : 0;
    teleRingN <= !(burst && cnt < GAP / 2);
  end
endmodule : ring_source_model

/* File: test/wakeup_event_router_assertions.sv */
`timescale 1ns/100ps
// ****
// Port checks of the event router
// ****
module wakeup_event_router_assertions (
  input wire logic                                core_clk,
  input wire logic                                srst,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [11:0]                         paddr,
  input wire logic [31:0]                         prdata,
  input wire logic                                pslverr,
  input wire logic                                pmChanOneSmi,
  input wire logic                                pmChanTwoSmi,
  input wire wakeup_event_router_pkg::host_out_t  hostOut,
  input wire logic                                coreWakeupInterrupt,
  input wire logic [15:0]                         configBaseAddr,
  input wire logic                                configAddrValid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Two idle bus cycles: no clear can be in flight
  sequence s_quiet; !psel [*2]; endsequence
  property p_pwrHold; s_quiet ##0 !hostOut.powerUpRequestN
    |=> !hostOut.powerUpRequestN; endproperty
  property p_irqHold; s_quiet ##0 hostOut.hostIrqReq
    |=> hostOut.hostIrqReq; endproperty
  property p_coreHold; s_quiet ##0 coreWakeupInterrupt
    |=> coreWakeupInterrupt; endproperty
  property p_smiOne; pmChanOneSmi |=> !hostOut.sysMgmtIntN; endproperty
  property p_smiTwo; pmChanTwoSmi |=> !hostOut.sysMgmtIntN; endproperty
  property p_validCause; $rose(configAddrValid) |->
    $past(psel && penable && pwrite && paddr == 12'h028); endproperty
  property p_baseLock; configAddrValid [*2] |-> $stable(configBaseAddr);
  endproperty
  property p_resetQuiet; $fell(srst) |-> hostOut.powerUpRequestN &&
    !hostOut.hostIrqReq && !coreWakeupInterrupt && !configAddrValid;
  endproperty
  property p_unmapped; psel && penable && paddr == 12'hFFC
    |-> pslverr && prdata == 32'h0; endproperty
  a_pwrHold: assert property (p_pwrHold)
    else $error("power-up request dropped");
  a_irqHold: assert property (p_irqHold)
    else $error("host irq dropped");
  a_coreHold: assert property (p_coreHold)
    else $error("core wake dropped");
  a_smiOne: assert property (p_smiOne)
    else $error("channel one request lost");
  a_smiTwo: assert property (p_smiTwo)
    else $error("channel two request lost");
  a_validCause: assert property (p_validCause)
    else $error("valid rose without lock");
  a_baseLock: assert property (p_baseLock)
    else $error("base moved while valid");
  a_resetQuiet: assert property (p_resetQuiet)
    else $error("outputs busy after reset");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access accepted");
endmodule : wakeup_event_router_assertions

bind wakeup_event_router wakeup_event_router_assertions i_chk (
  .core_clk, .srst, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
  .pmChanOneSmi, .pmChanTwoSmi, .hostOut, .coreWakeupInterrupt,
  .configBaseAddr, .configAddrValid);

/* File: test/wakeup_event_router_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  errCount++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module wakeup_event_router_tb;
  // ****
  // Stimulus and checking
  // ****
  logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, burst = 1'b0, teleRingN;
  logic ringA = 1'b1, ringB = 1'b1, alarm = 1'b0, smiA = 1'b0, smiB = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, ev, seed = 32'h0001_36D0;
  logic [3:0] modIrq = 4'h0, wakeEn = 4'h0;
  logic [15:0] base;
  logic valid, cw;
  wakeup_event_router_pkg::host_out_t hostOut;
  logic [31:0] expQ[$];           // Expected read data, oldest first
  int errCount = 0, comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  wakeup_event_router #(.NUM_DEV(4), .SLOT_CYCLES(16)) i_wakeup_event_router (
    .core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .modIrq, .modIrqWakeEn(wakeEn), .modemRingInAN(ringA),
    .modemRingInBN(ringB), .teleRingN, .rtcAlarmStatus(alarm),
    .pmChanOneSmi(smiA), .pmChanTwoSmi(smiB), .hostOut,
    .coreWakeupInterrupt(cw), .configBaseAddr(base), .configAddrValid(valid));
  ring_source_model #(.GAP(8)) i_ring_source_model (.core_clk, .burst,
    .teleRingN);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Setup, then access held until pready, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do @(posedge core_clk); while (!pready);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Read data watcher, registered so settled at the access edge
  always @(posedge core_clk) if (psel && penable && !pwrite && pready) begin
    ev = expQ.pop_front();
    `CHK("prdata", ev, prdata)
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin #100000; errCount++; give_verdict; end
  initial begin
    cyc(2);
    srst <= 1'b0;
    cyc(4);
    for (int a = 0; a < 16; a++) rd(12'(a * 4), 32'h0);
    rd(12'hFFC, 32'h0);
    for (int a = 1; a < 4; a++) begin
      seed = xs(seed);
      wr(12'(a * 4), seed);
      rd(12'(a * 4), seed & 32'h8B);
    end
    $display("registers done");
    wr(12'h004, 32'h81); wr(12'h008, 32'h0); wr(12'h00C, 32'h02);
    ringA <= 1'b0; ringB <= 1'b0; cyc(8);
    `CHK("pwrup", 1'b0, hostOut.powerUpRequestN)
    `CHK("irq", 1'b1, hostOut.hostIrqReq)
    wr(12'h000, 32'h0); rd(12'h000, 32'h03);
    wr(12'h00C, 32'h0); cyc(2);
    `CHK("irq", 1'b0, hostOut.hostIrqReq)
    rd(12'h000, 32'h03); wr(12'h000, 32'h01); cyc(2);
    `CHK("pwrup", 1'b1, hostOut.powerUpRequestN)
    wakeEn <= 4'h2; modIrq <= 4'h1; cyc(8);
    rd(12'h000, 32'h02); modIrq <= 4'h3; cyc(8);
    `CHK("pwrup", 1'b0, hostOut.powerUpRequestN)
    wr(12'h000, 32'h82); cyc(2);
    `CHK("pwrup", 1'b1, hostOut.powerUpRequestN)
    burst <= 1'b1; cyc(12); burst <= 1'b0; cyc(40);
    rd(12'h000, 32'h0);
    burst <= 1'b1; cyc(80); burst <= 1'b0; cyc(40);
    rd(12'h000, 32'h08); wr(12'h000, 32'h08);
    $display("host events done");
    wr(12'h034, 32'h1FF);
    for (int i = 0; i < 5; i++) begin
      wr(12'h010, 32'h1 << i);
      rd(12'h02C, 32'h2 << i);
      `CHK("cwake", 1'b1, cw)
      wr(12'h02C, 32'h2 << i);
    end
    wr(12'h010, 32'h0); rd(12'h02C, 32'h1); wr(12'h02C, 32'h1);
    wr(12'h010, 32'h10); wr(12'h034, 32'h1C0); cyc(2);
    `CHK("cwake", 1'b0, cw)
    rd(12'h02C, 32'h20); wr(12'h02C, 32'h20);
    wr(12'h014, 32'h2); rd(12'h02C, 32'h40); wr(12'h02C, 32'h40);
    wr(12'h014, 32'h1); rd(12'h02C, 32'h180);
    `CHK("cwake", 1'b1, cw)
    wr(12'h02C, 32'h100); rd(12'h02C, 32'h80);
    alarm <= 1'b1; cyc(8); rd(12'h030, 32'h1);
    `CHK("cwake", 1'b1, cw)
    wr(12'h030, 32'h1); alarm <= 1'b0; cyc(6); wr(12'h030, 32'h1);
    `CHK("cwake", 1'b0, cw)
    wr(12'h024, 32'h08); cyc(2);
    `CHK("cwake", 1'b1, cw)
    rd(12'h020, 32'h8B); rd(12'h000, 32'h0);
    wr(12'h020, 32'h8B); cyc(2);
    `CHK("cwake", 1'b0, cw)
    smiA <= 1'b1; cyc(2);
    `CHK("smi", 1'b0, hostOut.sysMgmtIntN)
    smiA <= 1'b0; smiB <= 1'b1; cyc(2);
    `CHK("smi", 1'b0, hostOut.sysMgmtIntN)
    smiB <= 1'b0; cyc(3);
    `CHK("smi", 1'b1, hostOut.sysMgmtIntN)
    $display("core events done");
    seed = xs(seed);
    wr(12'h028, 32'h1); wr(12'h038, {24'h0, seed[7:1], 1'b0});
    wr(12'h03C, {24'h0, seed[15:8]}); wr(12'h028, 32'h2);
    `CHK("base", {seed[15:8], seed[7:1], 1'b0}, base)
    `CHK("valid", 1'b1, valid)
    wr(12'h038, 32'hFF); rd(12'h038, {24'h0, seed[7:1], 1'b0});
    $display("config address done");
    give_verdict;
  end
endmodule : wakeup_event_router_tb
